/* src/ubd_pkg.sv */
// constants and carriers for the uart baud, interrupt and dma-ready block
// assumes one clock domain; config and fifo status come from logic on that clock
package ubd_pkg;

    localparam logic [7:0] ISR_NONE    = 8'h01;
    localparam logic [7:0] ISR_LINE    = 8'h06;
    localparam logic [7:0] ISR_RX      = 8'h04;
    localparam logic [7:0] ISR_TIMEOUT = 8'h0c;
    localparam logic [7:0] ISR_THR     = 8'h02;
    localparam logic [7:0] ISR_MODEM   = 8'h00;

    localparam int IER_RX_BIT    = 0;
    localparam int IER_THR_BIT   = 1;
    localparam int IER_LINE_BIT  = 2;
    localparam int IER_MODEM_BIT = 3;

    localparam logic [7:0] FULL_NORMAL = 8'h20;
    localparam logic [7:0] FULL_EXT    = 8'h80;

    localparam logic [2:0] PRESCALE_OFF = 3'h1;
    localparam logic [2:0] PRESCALE_ON  = 3'h4;

    localparam logic [9:0] TICKS_PER_BIT = 10'h010;
    localparam logic [9:0] STOP_ONE      = 10'h010;
    localparam logic [9:0] STOP_ONE_HALF = 10'h018;
    localparam logic [9:0] STOP_TWO      = 10'h020;
    localparam logic [9:0] MIN_DATA_BITS = 10'h005;
    localparam int         TIMEOUT_CHARS = 4;

    localparam logic       THR_PENDING_RESET = 1'b1;
    localparam logic       RX_READY_RESET    = 1'b1;

    typedef struct packed {
        logic [7:0] interrupt_enable_reg;
        logic [7:0] divisor_low_byte;
        logic [7:0] divisor_high_byte;
        logic [3:0] fractional_divisor_reg;
        logic       clock_prescale_select;
        logic       dma_mode_select;
        logic       fifo_enable;
        logic [1:0] word_length_sel;
        logic       parity_enable;
        logic       stop_long;
    } ubd_cfg_s;

    typedef struct packed {
        logic [7:0] tx_trigger_level_reg;
        logic [7:0] rx_trigger_level_reg;
        logic [7:0] flow_high_watermark_reg;
        logic [7:0] flow_low_watermark_reg;
    } ubd_ext_s;

    typedef struct packed {
        logic [7:0] rx_count;
        logic [7:0] tx_count;
        logic [7:0] rx_trigger;
    } ubd_fifo_s;

endpackage : ubd_pkg

/* src/ubd_core.sv */
// interrupt priority, receive time-out, rational baud generator, dma ready pins
// assumes fifo storage and serial shifters sit outside and share ref_clk_i
// Summary of operation
// R1: reset leaves transmit-empty interrupt pending
// R2: status shows only the highest pending source
// R3: data ready and time-out share enable bit
// R4: data interrupt once count reaches trigger
// R5: host rechecks data-available flag after reads
// R6: no time-out while receive fifo empty
// R7: time-out count restarts on stop centre, read
// R8: time-out equals four full character times
// R9: integer divisor from one to 65535
// R10: fractional divisor adds sixteenths per tick
// R11: prescale one or four by select bit
// R12: one baud tick serves transmitter and receiver
// R13: high and low bytes form divisor
// R14: dma select changes ready pin behaviour
// R15: non-dma rx ready high when empty
// R16: dma rx ready: up empty, down trigger/time-out
// R17: non-dma tx ready high when not empty
// R18: dma tx ready high only while full
// R19: full is 32, or 128 extended
// R20: fifo size change clears both fifos
module ubd_core (
    input  wire logic               ref_clk_i,
    input  wire logic               reset_i,
    input  wire ubd_pkg::ubd_cfg_s  cfg_i,
    input  wire ubd_pkg::ubd_ext_s  ext_i,
    input  wire ubd_pkg::ubd_fifo_s fifo_i,
    input  wire logic               line_status_pending_i,
    input  wire logic               modem_status_pending_i,
    input  wire logic               stop_bit_center_i,
    input  wire logic               rx_holding_read_i,
    input  wire logic               thr_write_i,
    input  wire logic               isr_read_i,
    output logic [7:0]              interrupt_source_o,
    output logic                    irq_o,
    output logic                    rx_timeout_o,
    output logic                    rx_data_available_flag_o,
    output logic                    baud_tick_o,
    output logic                    rx_ready_out_o,
    output logic                    tx_ready_out_o,
    output logic                    fifo_clear_o
);
    import ubd_pkg::*;

    logic [7:0]  isr_reg;
    logic [7:0]  isr_next;
    logic        irq_reg;
    logic        thr_pending_reg;
    logic        tx_empty_reg;
    logic [9:0]  tmo_cnt_reg;
    logic        timeout_reg;
    logic        avail_reg;
    logic [2:0]  pre_cnt_reg;
    logic [15:0] div_cnt_reg;
    logic [3:0]  frac_acc_reg;
    logic        stretch_reg;
    logic        tick_reg;
    logic        rx_rdy_reg;
    logic        tx_rdy_reg;
    logic        clear_reg;
    logic        prev_valid_reg;
    logic        prev_fen_reg;
    logic        prev_ext_reg;

    logic        rx_empty;
    logic        rx_level;
    logic        extended;
    logic [7:0]  full_level;
    logic [2:0]  presc;
    logic        pre_tick;
    logic [15:0] divisor;
    logic [15:0] div_end;
    logic [4:0]  frac_sum;
    logic [9:0]  char_ticks;
    logic [9:0]  tmo_limit;
    logic [9:0]  stop_ticks;
    logic        tmo_hit;

    assign rx_empty = (fifo_i.rx_count == 8'h00);
    assign rx_level = !rx_empty && (fifo_i.rx_count >= fifo_i.rx_trigger); // R4
    assign extended = (ext_i != '0); // R19
    assign full_level = extended ? FULL_EXT : FULL_NORMAL; // R19

    // interrupt source priority
    always_comb begin
        isr_next = ISR_NONE;
        if (line_status_pending_i && cfg_i.interrupt_enable_reg[IER_LINE_BIT]) begin
            isr_next = ISR_LINE; // R2
        end else if (rx_level && cfg_i.interrupt_enable_reg[IER_RX_BIT]) begin
            isr_next = ISR_RX; // R3
        end else if (timeout_reg && cfg_i.interrupt_enable_reg[IER_RX_BIT]) begin
            isr_next = ISR_TIMEOUT; // R3
        end else if (thr_pending_reg && cfg_i.interrupt_enable_reg[IER_THR_BIT]) begin
            isr_next = ISR_THR; // R1
        end else if (modem_status_pending_i && cfg_i.interrupt_enable_reg[IER_MODEM_BIT]) begin
            isr_next = ISR_MODEM; // R2
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            isr_reg <= ISR_NONE;
            irq_reg <= 1'b0;
        end else begin
            isr_reg <= isr_next; // R2
            irq_reg <= (isr_next != ISR_NONE);
        end
    end

    // transmit-empty pending; a fresh empty event beats the clear
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            thr_pending_reg <= THR_PENDING_RESET; // R1
            tx_empty_reg    <= 1'b1;
        end else begin
            tx_empty_reg <= (fifo_i.tx_count == 8'h00);
            if ((fifo_i.tx_count == 8'h00) && !tx_empty_reg) begin
                thr_pending_reg <= 1'b1;
            end else if (thr_write_i || (isr_read_i && isr_reg == ISR_THR)) begin
                thr_pending_reg <= 1'b0;
            end
        end
    end

    // one character in 16x ticks: start, data, parity, stop
    always_comb begin
        case ({cfg_i.stop_long, cfg_i.word_length_sel == 2'b00})
            2'b10:   stop_ticks = STOP_TWO;
            2'b11:   stop_ticks = STOP_ONE_HALF;
            default: stop_ticks = STOP_ONE;
        endcase
        char_ticks = TICKS_PER_BIT * (10'h001 + MIN_DATA_BITS + {8'h00, cfg_i.word_length_sel}
                     + {9'h000, cfg_i.parity_enable}) + stop_ticks; // R8
        tmo_limit  = 10'(TIMEOUT_CHARS) * char_ticks; // R8
    end

    assign tmo_hit = (tmo_cnt_reg == tmo_limit);

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            tmo_cnt_reg <= 10'h000;
        end else if (stop_bit_center_i || rx_holding_read_i || rx_empty) begin
            tmo_cnt_reg <= 10'h000; // R7
        end else if (tick_reg && !tmo_hit) begin
            tmo_cnt_reg <= tmo_cnt_reg + 10'h001; // R8
        end
    end

    // the count holds at its limit, so a hit sets the flag once and a restart can clear it
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            timeout_reg <= 1'b0;
        end else if (rx_empty) begin
            timeout_reg <= 1'b0; // R6
        end else if (tmo_hit && !timeout_reg) begin
            timeout_reg <= 1'b1; // R8
        end else if (stop_bit_center_i || rx_holding_read_i) begin
            timeout_reg <= 1'b0; // R7
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            avail_reg <= 1'b0;
        end else begin
            avail_reg <= !rx_empty; // R5
        end
    end

    // baud generator: prescale, then N cycles plus one in M of every 16 ticks
    assign presc    = cfg_i.clock_prescale_select ? PRESCALE_ON : PRESCALE_OFF; // R11
    assign pre_tick = (pre_cnt_reg == presc - 3'h1);
    assign divisor  = {cfg_i.divisor_high_byte, cfg_i.divisor_low_byte}; // R13
    assign div_end  = divisor - 16'h0001 + {15'h0000, stretch_reg}; // R10
    assign frac_sum = {1'b0, frac_acc_reg} + {1'b0, cfg_i.fractional_divisor_reg};

    always_ff @(posedge ref_clk_i) begin
        if (reset_i || pre_tick) begin
            pre_cnt_reg <= 3'h0;
        end else begin
            pre_cnt_reg <= pre_cnt_reg + 3'h1; // R11
        end
    end

    // divisor zero is outside the legal range and halts the tick
    always_ff @(posedge ref_clk_i) begin
        if (reset_i || divisor == 16'h0000) begin
            div_cnt_reg  <= 16'h0000;
            frac_acc_reg <= 4'h0;
            stretch_reg  <= 1'b0;
            tick_reg     <= 1'b0;
        end else begin
            tick_reg <= 1'b0;
            if (pre_tick) begin
                if (div_cnt_reg >= div_end) begin
                    div_cnt_reg  <= 16'h0000; // R9
                    frac_acc_reg <= frac_sum[3:0]; // R10
                    stretch_reg  <= frac_sum[4];
                    tick_reg     <= 1'b1; // R12
                end else begin
                    div_cnt_reg <= div_cnt_reg + 16'h0001;
                end
            end
        end
    end

    // ready pins
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            rx_rdy_reg <= RX_READY_RESET;
        end else if (!cfg_i.dma_mode_select) begin
            rx_rdy_reg <= rx_empty; // R15
        end else if (rx_empty) begin
            rx_rdy_reg <= 1'b1; // R16
        end else if ((fifo_i.rx_count >= fifo_i.rx_trigger) || timeout_reg) begin
            rx_rdy_reg <= 1'b0; // R16
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            tx_rdy_reg <= 1'b0;
        end else if (!cfg_i.dma_mode_select) begin
            tx_rdy_reg <= (fifo_i.tx_count != 8'h00); // R17
        end else begin
            tx_rdy_reg <= (fifo_i.tx_count >= full_level); // R14 R18 R19
        end
    end

    // size change detect; the first cycle after reset only samples
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            prev_valid_reg <= 1'b0;
            prev_fen_reg   <= 1'b0;
            prev_ext_reg   <= 1'b0;
            clear_reg      <= 1'b0;
        end else begin
            prev_valid_reg <= 1'b1;
            prev_fen_reg   <= cfg_i.fifo_enable;
            prev_ext_reg   <= extended;
            clear_reg      <= prev_valid_reg && ((prev_fen_reg != cfg_i.fifo_enable)
                              || (prev_ext_reg != extended)); // R20
        end
    end

    assign interrupt_source_o       = isr_reg;
    assign irq_o                    = irq_reg;
    assign rx_timeout_o             = timeout_reg;
    assign rx_data_available_flag_o = avail_reg;
    assign baud_tick_o              = tick_reg;
    assign rx_ready_out_o           = rx_rdy_reg;
    assign tx_ready_out_o           = tx_rdy_reg;
    assign fifo_clear_o             = clear_reg;

    // gap between ticks, for checking only; a config change spoils one gap
    logic [23:0] gap_reg;
    logic        seen_reg;
    ubd_cfg_s    cfg_seen_reg;
    always_ff @(posedge ref_clk_i) begin
        cfg_seen_reg <= cfg_i;
        if (reset_i || tick_reg) begin
            gap_reg  <= 24'h000001;
            seen_reg <= !reset_i && (cfg_i == cfg_seen_reg);
        end else begin
            gap_reg <= gap_reg + 24'h000001;
            if (cfg_i != cfg_seen_reg) begin
                seen_reg <= 1'b0;
            end
        end
    end

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (reset_i);

    AST_THR_AFTER_RESET: assert property ( // R1
        $fell(reset_i) |-> thr_pending_reg)
        else $error("transmit-empty not pending after reset");
    AST_LINE_FIRST: assert property ( // R2
        line_status_pending_i && cfg_i.interrupt_enable_reg[IER_LINE_BIT]
        |=> isr_reg == ISR_LINE)
        else $error("line status not reported first");
    AST_RX_SHARED: assert property ( // R3
        !cfg_i.interrupt_enable_reg[IER_RX_BIT]
        |=> isr_reg != ISR_RX && isr_reg != ISR_TIMEOUT)
        else $error("receive source reported while disabled");
    AST_RX_LEVEL: assert property ( // R4
        rx_level && cfg_i.interrupt_enable_reg[IER_RX_BIT]
        && !(line_status_pending_i && cfg_i.interrupt_enable_reg[IER_LINE_BIT])
        |=> isr_reg == ISR_RX)
        else $error("trigger level not reported");
    AST_NO_TMO_EMPTY: assert property ( // R6
        rx_empty |=> !timeout_reg)
        else $error("time-out with empty fifo");
    AST_TMO_RESTART: assert property ( // R7
        stop_bit_center_i || rx_holding_read_i |=> tmo_cnt_reg == 10'h000)
        else $error("time-out count not restarted");
    AST_TMO_VALUE: assert property ( // R8
        $rose(timeout_reg) |-> $past(tmo_cnt_reg) == $past(tmo_limit))
        else $error("time-out raised at wrong count");
    AST_TICK_GAP: assert property ( // R10
        tick_reg && seen_reg && $stable(cfg_i) |->
        (gap_reg >= 24'(divisor) * 24'(presc)) && (gap_reg <= 24'(divisor + 16'h0001) * 24'(presc)))
        else $error("baud tick spacing wrong");
    AST_RX_RDY_NORMAL: assert property ( // R15
        !cfg_i.dma_mode_select |=> rx_rdy_reg == $past(rx_empty))
        else $error("rx ready wrong outside dma");
    AST_RX_RDY_DMA: assert property ( // R16
        cfg_i.dma_mode_select && rx_level |=> !rx_rdy_reg)
        else $error("rx ready not dropped at trigger");
    AST_TX_RDY_NORMAL: assert property ( // R17
        !cfg_i.dma_mode_select |=> tx_rdy_reg == ($past(fifo_i.tx_count) != 8'h00))
        else $error("tx ready wrong outside dma");
    AST_TX_RDY_DMA: assert property ( // R18
        cfg_i.dma_mode_select |=> tx_rdy_reg == ($past(fifo_i.tx_count) >= $past(full_level)))
        else $error("tx ready wrong in dma");
    AST_SIZE_CLEAR: assert property ( // R20
        prev_valid_reg && (prev_ext_reg != extended) |=> clear_reg)
        else $error("size change did not clear fifos");
    AST_FEN_CLEAR: assert property ( // R20
        prev_valid_reg && (prev_fen_reg != cfg_i.fifo_enable) |=> clear_reg)
        else $error("fifo enable toggle did not clear fifos");
    AST_THR_SET_WINS: assert property ( // R1
        (fifo_i.tx_count == 8'h00) && !tx_empty_reg |=> thr_pending_reg)
        else $error("transmit-empty event lost");
    AST_THR_CLEAR: assert property ( // R1
        thr_write_i && !((fifo_i.tx_count == 8'h00) && !tx_empty_reg) |=> !thr_pending_reg)
        else $error("transmit write did not clear pending");
    AST_TMO_CLEAR: assert property ( // R7
        timeout_reg && (stop_bit_center_i || rx_holding_read_i) |=> !timeout_reg)
        else $error("time-out not cleared by restart");
    AST_RX_RDY_EMPTY: assert property ( // R16
        cfg_i.dma_mode_select && rx_empty |=> rx_rdy_reg)
        else $error("rx ready not raised on empty");
    AST_IRQ_LINE: assert property ( // R2
        line_status_pending_i && cfg_i.interrupt_enable_reg[IER_LINE_BIT] |=> irq_reg)
        else $error("interrupt not raised for line status");

    COV_TIMEOUT: cover property (cfg_i.interrupt_enable_reg[IER_RX_BIT] ##1 isr_reg == ISR_TIMEOUT);
    COV_DMA_RX: cover property (cfg_i.dma_mode_select && rx_rdy_reg ##1 !rx_rdy_reg);
    COV_FRAC_TICK: cover property (tick_reg && stretch_reg);
    COV_CLEAR: cover property (clear_reg);
    COV_TX_FULL: cover property (cfg_i.dma_mode_select && extended ##1 tx_rdy_reg);

endmodule : ubd_core

/* verif/ubd_host_model.sv */
// host or dma side model: owns fifo levels and the host strobes
// assumes the bench calls its tasks; strobes move 2 ns after the clock rises
module ubd_host_model (
    input  wire logic               ref_clk_i,
    input  wire logic               rx_flag_i,
    output ubd_pkg::ubd_fifo_s      fifo_o,
    output logic [3:0]              strobe_o
);
    timeunit 1ns;
    timeprecision 1ps;
    import ubd_pkg::*;

    initial begin
        fifo_o   = '0;
        strobe_o = 4'h0;
    end

    task automatic set_fifo(input logic [7:0] rx, input logic [7:0] tx, input logic [7:0] trig);
        @(posedge ref_clk_i);
        #2;
        fifo_o = {rx, tx, trig};
    endtask : set_fifo

    // 0 stop centre, 1 holding read, 2 transmit write, 3 source read
    task automatic strobe(input int idx);
        @(posedge ref_clk_i);
        #2;
        strobe_o[idx] = 1'b1;
        @(posedge ref_clk_i);
        #2;
        strobe_o[idx] = 1'b0;
    endtask : strobe

    // one byte taken, then the data flag is looked at again
    task automatic pop_rx(output logic more);
        @(posedge ref_clk_i);
        #2;
        strobe_o[1]     = 1'b1;
        fifo_o.rx_count = fifo_o.rx_count - 8'h01;
        @(posedge ref_clk_i);
        #2;
        strobe_o[1] = 1'b0;
        repeat (2) @(posedge ref_clk_i);
        #2;
        more = rx_flag_i;
    endtask : pop_rx
endmodule : ubd_host_model

/* verif/test_uart_baud_irq_dma_ready.sv */
// self-checking bench for ubd_core: priority, time-out, baud, ready pins, fifo clear
// assumes ubd_host_model drives fifo levels and strobes; the bench drives config
module test_uart_baud_irq_dma_ready;
    timeunit 1ns;
    timeprecision 1ps;
    import ubd_pkg::*;

    logic       ref_clk = 1'b0;
    logic       reset   = 1'b1;
    logic       line_p  = 1'b0;
    logic       modem_p = 1'b0;
    ubd_cfg_s   cfg     = {8'h0f, 8'h01, 8'h00, 4'h0, 1'b0, 1'b0, 1'b1, 2'h3, 1'b0, 1'b0};
    ubd_ext_s   ext     = '0;
    ubd_fifo_s  fifo;
    logic [3:0] stb;
    logic [7:0] interrupt_source_reg;
    logic       irq, tmo, rx_flag, tick, rx_rdy, tx_rdy, clr, more, bad;
    int         error_cnt  = 0;
    int         num_checks = 0;

    always #12.5 ref_clk = ~ref_clk;

    ubd_host_model ubd_host_model_i (.ref_clk_i(ref_clk), .rx_flag_i(rx_flag), .fifo_o(fifo),
        .strobe_o(stb));
    ubd_core ubd_core_i (.ref_clk_i(ref_clk), .reset_i(reset), .cfg_i(cfg), .ext_i(ext),
        .fifo_i(fifo), .line_status_pending_i(line_p), .modem_status_pending_i(modem_p),
        .stop_bit_center_i(stb[0]), .rx_holding_read_i(stb[1]), .thr_write_i(stb[2]),
        .isr_read_i(stb[3]), .interrupt_source_o(interrupt_source_reg), .irq_o(irq), .rx_timeout_o(tmo),
        .rx_data_available_flag_o(rx_flag), .baud_tick_o(tick), .rx_ready_out_o(rx_rdy),
        .tx_ready_out_o(tx_rdy), .fifo_clear_o(clr));

    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #2;
    endtask : cyc

    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: %s is %h, expected %h", $time, what, seen, exp);
        end
    endtask : check

    task automatic complete_run();
        $display("checks %0d, errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : complete_run

    // sixteen tick intervals sum to presc*(16n+m) whatever the fraction phase
    task automatic baud(input logic [15:0] n, input logic [3:0] m, input logic ps, input int exp);
        int cnt;
        int ticks;
        cnt   = 0;
        ticks = -3;
        {cfg.divisor_high_byte, cfg.divisor_low_byte} = n;
        cfg.fractional_divisor_reg = m;
        cfg.clock_prescale_select  = ps;
        for (int i = 0; i < 20000 && ticks < 16; i++) begin
            cyc(1);
            if (ticks >= 0) cnt++;
            if (tick === 1'b1) ticks++;
        end
        check(cnt[15:0], exp[15:0], "baud span");
        if (ticks < 16) begin
            error_cnt++;
            complete_run();
        end
    endtask : baud

    // divisor 1 gives one tick a cycle, so the limit is counted in cycles
    task automatic tmo_case(input logic [1:0] w, input logic par, input logic sl, input int src);
        int lim;
        int n;
        lim = 4 * (16 * (6 + w + par) + (sl ? (w == 2'h0 ? 24 : 32) : 16));
        cfg.word_length_sel = w;
        cfg.parity_enable   = par;
        cfg.stop_long       = sl;
        ubd_host_model_i.strobe(src);
        n = 0;
        while (tmo !== 1'b1 && n < lim + 50) begin
            cyc(1);
            n++;
        end
        check(n >= lim - 1 && n <= lim + 4, 1'b1, "time-out span");
        if (tmo !== 1'b1) complete_run();
        cyc(1);
        check({tmo, rx_rdy, interrupt_source_reg}, {2'b10, ISR_TIMEOUT}, "time-out state");
        ubd_host_model_i.strobe(1 - src);
        cyc(1);
        check(tmo, 1'b0, "time-out restart");
    endtask : tmo_case

    task automatic ready(input logic dma, input logic e, input logic [7:0] rx,
                         input logic [7:0] tx, input logic [1:0] exp);
        cfg.dma_mode_select = dma;
        ext = e ? 32'h0000_0040 : 32'h0000_0000;
        ubd_host_model_i.set_fifo(rx, tx, 8'h08);
        cyc(2);
        check({rx_rdy, tx_rdy}, exp, "ready pins");
    endtask : ready

    task automatic clears(input int exp);
        int n;
        n = 0;
        repeat (4) begin
            cyc(1);
            if (clr === 1'b1) n++;
        end
        check(n[15:0], exp[15:0], "fifo clear pulses");
    endtask : clears

    initial begin
        repeat (20) @(posedge ref_clk);
        #2;
        reset = 1'b0;
        cyc(2);
        check({irq, rx_rdy, tx_rdy, interrupt_source_reg}, {3'b110, ISR_THR}, "after reset");
        line_p = 1'b1;
        ubd_host_model_i.set_fifo(8'h08, 8'h00, 8'h08);
        cyc(2);
        check(interrupt_source_reg, ISR_LINE, "line over rx");
        line_p = 1'b0;
        cyc(2);
        check(interrupt_source_reg, ISR_RX, "rx at trigger");
        cfg.interrupt_enable_reg = 8'h0e;
        cyc(2);
        check(interrupt_source_reg, ISR_THR, "rx masked");
        cfg.interrupt_enable_reg = 8'h0f;
        ubd_host_model_i.pop_rx(more);
        check({more, interrupt_source_reg}, {1'b1, ISR_THR}, "below trigger");
        ubd_host_model_i.strobe(3);
        cyc(1);
        check(interrupt_source_reg, ISR_NONE, "transmit empty served");
        modem_p = 1'b1;
        cyc(2);
        check(interrupt_source_reg, ISR_MODEM, "modem lowest");
        ubd_host_model_i.set_fifo(8'h07, 8'h01, 8'h08);
        ubd_host_model_i.set_fifo(8'h07, 8'h00, 8'h08);
        cyc(2);
        check(interrupt_source_reg, ISR_THR, "transmit over modem");
        ubd_host_model_i.strobe(2);
        cyc(1);
        check(interrupt_source_reg, ISR_MODEM, "transmit write served");
        modem_p = 1'b0;
        baud(16'h0003, 4'h0, 1'b0, 48);
        baud(16'h0003, 4'h8, 1'b0, 56);
        baud(16'h0002, 4'hf, 1'b1, 188);
        baud(16'h0100, 4'h0, 1'b0, 4096);
        baud(16'h0001, 4'h0, 1'b0, 16);
        cfg.dma_mode_select = 1'b1;
        ubd_host_model_i.set_fifo(8'h00, 8'h00, 8'h08);
        ubd_host_model_i.set_fifo(8'h01, 8'h00, 8'h08);
        tmo_case(2'h3, 1'b0, 1'b0, 0);
        tmo_case(2'h0, 1'b1, 1'b1, 1);
        tmo_case(2'h3, 1'b1, 1'b1, 0);
        tmo_case(2'h1, 1'b0, 1'b0, 1);
        ubd_host_model_i.set_fifo(8'h00, 8'h00, 8'h08);
        bad = 1'b0;
        repeat (900) begin
            cyc(1);
            if (tmo !== 1'b0) bad = 1'b1;
        end
        check({bad, rx_rdy}, 2'b01, "empty fifo");
        ready(1'b0, 1'b0, 8'h00, 8'h00, 2'b10);
        ready(1'b0, 1'b0, 8'h03, 8'h05, 2'b01);
        ready(1'b1, 1'b0, 8'h00, 8'h1f, 2'b10);
        ready(1'b1, 1'b0, 8'h05, 8'h20, 2'b11);
        ready(1'b1, 1'b0, 8'h08, 8'h1f, 2'b00);
        ready(1'b1, 1'b0, 8'h05, 8'h20, 2'b01);
        ready(1'b1, 1'b1, 8'h00, 8'h20, 2'b10);
        ready(1'b1, 1'b1, 8'h00, 8'h7f, 2'b10);
        ready(1'b1, 1'b1, 8'h00, 8'h80, 2'b11);
        ext = 32'h0100_0000;
        clears(0);
        ext = 32'h0000_0000;
        clears(1);
        cfg.fifo_enable = 1'b0;
        clears(1);
        cfg.fifo_enable = 1'b1;
        clears(1);
        complete_run();
    end

    // hang guard
    initial begin
        repeat (100000) @(posedge ref_clk);
        error_cnt++;
        complete_run();
    end
endmodule : test_uart_baud_irq_dma_ready
